// *** rtl/ccs_config_regs.sv ***
// What this block does
// - Index 000001 selects contiguous I/O, task file at x0h..xFh.
// - Index 000000 is memory mode, task file at 0h..Fh and 400h..7FFh.
// - Index 000010 decodes primary I/O at 1F0h..1F7h and 3F6h..3F7h.
// - Index 000011 decodes secondary I/O at 170h..177h and 376h..377h.
// - Mode-select register reads zero after power-up; card starts in memory mode.
// - Status register resets to zero; fixed bit layout, bits 4,3,0 read zero.
// - Change flag is set while ready-change or write-protect-change flag is one.
// - Change set, enable set and I/O mode drive status-changed pin low.
// - In I/O mode with enable clear, the status pin is held high.
// - Byte-I/O bit is stored but ignored; 8 and 16 bit always work.
// - Power-save bit one enters power-down, zero returns active; reads back.
// - Any change of power-save bit reports busy at once.
// - Busy holds until the requested power state is reached.
// - Card powers down by itself when idle and wakes on a command.
// - Interrupt bit mirrors internal request in every mode until serviced.
// - Interrupt bit is forced zero while host interrupts are disabled.
// - Soft reset acts as hardware reset but stays set; clearing leaves unconfigured.
// - Level select one gives level interrupts, zero gives pulse interrupts.
// - Ready-change flag is set whenever the internal ready state changes.
// - Mode-select at attribute 200h, status register at 202h.
//
// Purpose: Mode-select and configuration/status registers of a storage card
// Assumes: Card bus pins sampled synchronously to clk_sys
// Notes:   Reserved index values decode no task file
`timescale 1ns/10ps
`include "ccs_consts.svh"

module ccs_config_regs #(
  parameter int SETTLE_CYC = `CCS_PWR_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  // Card bus
  input  wire logic                   ce1_n,
  input  wire logic                   reg_n,
  input  wire logic                   oe_n,
  input  wire logic                   we_n,
  input  wire logic                   iord_n,
  input  wire logic                   iowr_n,
  input  wire logic [10:0]            addr,
  input  wire logic [7:0]             data_in,
  output logic      [7:0]             data_out,
  output logic                        data_oe,
  // Pin replacement side
  input  wire logic                   wp_change_flag,
  input  wire logic                   ready_change_clear,
  output logic                        ready_change_flag,
  output logic                        ready_state,
  // Drive core
  input  wire logic                   irq_request,
  input  wire logic                   host_irq_disable,
  input  wire logic                   card_idle,
  input  wire logic                   command_arrive,
  // Outputs
  output logic                        status_changed_pin_n,
  output logic                        irq_n,
  output logic                        card_reset,
  output logic                        powered_down,
  output ccs_pkg::ccs_mode_t          mode,
  output logic                        task_hit,
  output logic      [3:0]             task_reg
);
  import ccs_pkg::*;

  logic [7:0]  ms_r, ms_nxt;
  logic        status_change_enable_r, status_change_enable_nxt;
  logic        byteio_r, byteio_nxt;
  logic        pwrsave_r, pwrsave_nxt;
  logic        rdy_chg_r, rdy_chg_nxt;
  logic        rdy_prev_r;
  logic        int_prev_r;
  logic [7:0]  dout_nxt;
  logic        doe_nxt;
  logic        stsn_nxt, irqn_nxt, hit_nxt;
  logic [3:0]  treg_nxt;
  ccs_mode_t   mode_nxt;
  logic        we_prev_r;
  logic        attr_sel, wr_stb, rd_act;
  logic        hit_ms, hit_sc;
  logic        pwr_busy, pwr_down;
  logic        int_bit, changed, io_mode, srst;
  logic [5:0]  idx;
  logic [7:0]  sc_view;

  ccs_power_ctrl #(
    .SETTLE_CYC         (SETTLE_CYC)
  ) u_power (
    .clk_sys            (clk_sys),
    .reset_n            (reset_n),
    .power_save_request (pwrsave_r),
    .card_idle          (card_idle),
    .command_arrive     (command_arrive),
    .powered_down_r     (pwr_down),
    .busy_r             (pwr_busy)
  );

  assign srst     = ms_r[`CCS_MS_SOFT_RESET_BIT_BIT];
  assign idx      = ms_r[`CCS_MS_INDEX_HI:`CCS_MS_INDEX_LO];
  assign io_mode  = idx != `CCS_IDX_MEMORY;
  assign int_bit  = irq_request && !host_irq_disable;
  assign changed  = rdy_chg_r || wp_change_flag;
  assign attr_sel = !ce1_n && !reg_n && !addr[0];
  assign hit_ms   = attr_sel && addr == `CCS_ATTR_MODE_SEL;
  assign hit_sc   = attr_sel && addr == `CCS_ATTR_STAT_CTRL;
  assign wr_stb   = !we_n && we_prev_r;
  assign rd_act   = !oe_n && we_n;

  // Status view; bits 4, 3 and 0 are constant zero
  always_comb begin
    sc_view                      = 8'h00;
    sc_view[`CCS_SC_CHANGED_BIT] = changed;
    sc_view[`CCS_SC_STATUS_CHANGE_ENABLE_BIT]  = status_change_enable_r;
    sc_view[`CCS_SC_BYTEIO_BIT]  = byteio_r;
    sc_view[`CCS_SC_PWRSAVE_BIT] = pwrsave_r;
    sc_view[`CCS_SC_INT_BIT]     = int_bit;
  end

  // Register writes and soft reset
  always_comb begin
    ms_nxt      = ms_r;
    status_change_enable_nxt  = status_change_enable_r;
    byteio_nxt  = byteio_r;
    pwrsave_nxt = pwrsave_r;
    if (wr_stb && hit_ms) begin
      ms_nxt = data_in;
    end
    if (wr_stb && hit_sc && !srst) begin
      status_change_enable_nxt  = data_in[`CCS_SC_STATUS_CHANGE_ENABLE_BIT];
      byteio_nxt  = data_in[`CCS_SC_BYTEIO_BIT];
      pwrsave_nxt = data_in[`CCS_SC_PWRSAVE_BIT];
    end
    if (ms_nxt[`CCS_MS_SOFT_RESET_BIT_BIT]) begin
      ms_nxt      = `CCS_MODE_SEL_RESET;
      ms_nxt[`CCS_MS_SOFT_RESET_BIT_BIT] = 1'b1;
      status_change_enable_nxt  = 1'b0;
      byteio_nxt  = 1'b0;
      pwrsave_nxt = 1'b0;
    end
  end

  // Ready state and its change flag; a new change beats a clear
  assign ready_state = !pwr_busy;
  always_comb begin
    rdy_chg_nxt = rdy_chg_r;
    if (ready_change_clear) begin
      rdy_chg_nxt = 1'b0;
    end
    if (ready_state != rdy_prev_r) begin
      rdy_chg_nxt = 1'b1;
    end
  end

  // Readback, status pin, interrupt and task file decode
  always_comb begin
    dout_nxt = 8'h00;
    doe_nxt  = 1'b0;
    if (rd_act && hit_ms) begin
      dout_nxt = ms_r;
      doe_nxt  = 1'b1;
    end else if (rd_act && hit_sc) begin
      dout_nxt = sc_view;
      doe_nxt  = 1'b1;
    end
    stsn_nxt = 1'b1;
    if (io_mode && status_change_enable_r && changed) begin
      stsn_nxt = 1'b0;
    end
    if (ms_r[`CCS_MS_LEVEL_BIT]) begin
      irqn_nxt = !int_bit;
    end else begin
      irqn_nxt = !(int_bit && !int_prev_r);
    end
    hit_nxt  = 1'b0;
    treg_nxt = addr[3:0];
    case (idx)
      `CCS_IDX_MEMORY: begin
        mode_nxt = CCS_MODE_MEMORY;
        hit_nxt  = !ce1_n && reg_n && (!oe_n || !we_n)
                   && (addr[10:4] == 7'h00 || addr[10]);
      end
      `CCS_IDX_CONTIG: begin
        mode_nxt = CCS_MODE_CONTIG;
        hit_nxt  = !ce1_n && !reg_n && (!iord_n || !iowr_n);
      end
      `CCS_IDX_PRIMARY: begin
        mode_nxt = CCS_MODE_PRIMARY;
        hit_nxt  = !ce1_n && !reg_n && (!iord_n || !iowr_n)
                   && ({addr[10:3], 3'b000} == `CCS_PRI_BASE
                       || {addr[10:1], 1'b0} == `CCS_PRI_ALT);
        // A9 splits the base block from the alternate pair
        treg_nxt = addr[9] ? (`CCS_ALT_REG_BASE | {3'b000, addr[0]}) : {1'b0, addr[2:0]};
      end
      `CCS_IDX_SECONDARY: begin
        mode_nxt = CCS_MODE_SECONDARY;
        hit_nxt  = !ce1_n && !reg_n && (!iord_n || !iowr_n)
                   && ({addr[10:3], 3'b000} == `CCS_SEC_BASE
                       || {addr[10:1], 1'b0} == `CCS_SEC_ALT);
        treg_nxt = addr[9] ? (`CCS_ALT_REG_BASE | {3'b000, addr[0]}) : {1'b0, addr[2:0]};
      end
      default: begin
        mode_nxt = CCS_MODE_CONTIG;
        hit_nxt  = 1'b0;
      end
    endcase
    if (srst || pwr_down) begin
      hit_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ms_r                 <= `CCS_MODE_SEL_RESET;
      status_change_enable_r             <= 1'b0;
      byteio_r             <= 1'b0;
      pwrsave_r            <= 1'b0;
      rdy_chg_r            <= 1'b0;
      rdy_prev_r           <= 1'b1;
      int_prev_r           <= 1'b0;
      we_prev_r            <= 1'b1;
      data_out             <= 8'h00;
      data_oe              <= 1'b0;
      status_changed_pin_n <= 1'b1;
      irq_n                <= 1'b1;
      card_reset           <= 1'b0;
      powered_down         <= 1'b0;
      mode                 <= CCS_MODE_MEMORY;
      task_hit             <= 1'b0;
      task_reg             <= 4'h0;
      ready_change_flag    <= 1'b0;
    end else begin
      ms_r                 <= ms_nxt;
      status_change_enable_r             <= status_change_enable_nxt;
      byteio_r             <= byteio_nxt;
      pwrsave_r            <= pwrsave_nxt;
      rdy_chg_r            <= rdy_chg_nxt;
      rdy_prev_r           <= ready_state;
      int_prev_r           <= int_bit;
      we_prev_r            <= we_n;
      data_out             <= dout_nxt;
      data_oe              <= doe_nxt;
      status_changed_pin_n <= stsn_nxt;
      irq_n                <= irqn_nxt;
      card_reset           <= ms_nxt[`CCS_MS_SOFT_RESET_BIT_BIT];
      powered_down         <= pwr_down;
      mode                 <= mode_nxt;
      task_hit             <= hit_nxt;
      task_reg             <= treg_nxt;
      ready_change_flag    <= rdy_chg_nxt;
    end
  end

endmodule

// *** rtl/ccs_consts.svh ***
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 250 MHz system clock
// Notes:   Attribute addresses are byte addresses on the card address pins
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

`define CCS_ADDR_W           11
`define CCS_ATTR_MODE_SEL    11'h200
`define CCS_ATTR_STAT_CTRL   11'h202

`define CCS_MODE_SEL_RESET   8'h00
`define CCS_STAT_CTRL_RESET  8'h00

`define CCS_MS_SOFT_RESET_BIT_BIT    7
`define CCS_MS_LEVEL_BIT     6
`define CCS_MS_INDEX_HI      5
`define CCS_MS_INDEX_LO      0

`define CCS_SC_CHANGED_BIT   7
`define CCS_SC_STATUS_CHANGE_ENABLE_BIT    6
`define CCS_SC_BYTEIO_BIT    5
`define CCS_SC_PWRSAVE_BIT   2
`define CCS_SC_INT_BIT       1

`define CCS_IDX_MEMORY       6'h00
`define CCS_IDX_CONTIG       6'h01
`define CCS_IDX_PRIMARY      6'h02
`define CCS_IDX_SECONDARY    6'h03

`define CCS_MEM_MIRROR_LO    11'h400
`define CCS_PRI_BASE         11'h1F0
`define CCS_PRI_ALT          11'h3F6
`define CCS_SEC_BASE         11'h170
`define CCS_SEC_ALT          11'h376
`define CCS_ALT_REG_BASE     4'he

`define CCS_CLK_MHZ          250
`define CCS_PWR_SETTLE_NS    1000
`define CCS_PWR_SETTLE_CYC   ((`CCS_PWR_SETTLE_NS * `CCS_CLK_MHZ + 999) / 1000)

`endif

// *** rtl/ccs_pkg.sv ***
// Purpose: Types shared by the card configuration and status block
// Assumes: Constants live in ccs_consts.svh
// Notes:   One-hot state codes written out
package ccs_pkg;

  typedef enum logic [3:0] {
    CCS_MODE_MEMORY    = 4'b0001,
    CCS_MODE_CONTIG    = 4'b0010,
    CCS_MODE_PRIMARY   = 4'b0100,
    CCS_MODE_SECONDARY = 4'b1000
  } ccs_mode_t;

  typedef enum logic [3:0] {
    CCS_PWR_ACTIVE  = 4'b0001,
    CCS_PWR_ENTER   = 4'b0010,
    CCS_PWR_DOWN    = 4'b0100,
    CCS_PWR_EXIT    = 4'b1000
  } ccs_pwr_state_t;

endpackage

// *** rtl/ccs_power_ctrl.sv ***
// Purpose: Power state sequencer with busy reporting
// Assumes: Requests synchronous to clk_sys
// Notes:   Busy covers every transition, requested or automatic
`timescale 1ns/10ps
`include "ccs_consts.svh"

module ccs_power_ctrl #(
  parameter int SETTLE_CYC = `CCS_PWR_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Requests
  input  wire logic power_save_request,
  input  wire logic card_idle,
  input  wire logic command_arrive,
  // State
  output logic      powered_down_r,
  output logic      busy_r
);
  import ccs_pkg::*;

  ccs_pwr_state_t state_r, state_nxt;
  logic [15:0]    cnt_r, cnt_nxt;
  logic           req_prev_r, req_prev_nxt;
  logic           auto_r, auto_nxt;
  logic           pd_nxt, busy_nxt;
  logic           req_change;

  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    auto_nxt     = auto_r;
    req_prev_nxt = power_save_request;
    req_change   = power_save_request != req_prev_r;
    busy_nxt     = busy_r;
    pd_nxt       = powered_down_r;
    if (req_change) begin
      busy_nxt = 1'b1;
    end
    case (state_r)
      CCS_PWR_ACTIVE: begin
        if (power_save_request || (card_idle && !command_arrive)) begin
          auto_nxt  = !power_save_request;
          state_nxt = CCS_PWR_ENTER;
          cnt_nxt   = 16'(SETTLE_CYC);
          busy_nxt  = 1'b1;
        end else if (!req_change) begin
          busy_nxt = 1'b0;
        end
      end
      CCS_PWR_ENTER: begin
        if (cnt_r <= 16'h0001) begin
          state_nxt = CCS_PWR_DOWN;
          pd_nxt    = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      CCS_PWR_DOWN: begin
        if ((!power_save_request && !auto_r) || (auto_r && command_arrive)
            || (auto_r && power_save_request == 1'b0 && req_change)) begin
          state_nxt = CCS_PWR_EXIT;
          cnt_nxt   = 16'(SETTLE_CYC);
          busy_nxt  = 1'b1;
        end else begin
          if (power_save_request) begin
            auto_nxt = 1'b0;
          end
          if (!req_change) begin
            busy_nxt = 1'b0;
          end
        end
      end
      CCS_PWR_EXIT: begin
        if (cnt_r <= 16'h0001) begin
          state_nxt = CCS_PWR_ACTIVE;
          pd_nxt    = 1'b0;
          auto_nxt  = 1'b0;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      default: begin
        state_nxt = CCS_PWR_ACTIVE;
        pd_nxt    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r        <= CCS_PWR_ACTIVE;
      cnt_r          <= 16'h0000;
      req_prev_r     <= 1'b0;
      auto_r         <= 1'b0;
      powered_down_r <= 1'b0;
      busy_r         <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      cnt_r          <= cnt_nxt;
      req_prev_r     <= req_prev_nxt;
      auto_r         <= auto_nxt;
      powered_down_r <= pd_nxt;
      busy_r         <= busy_nxt;
    end
  end

endmodule

// *** test/ccs_host_model.sv ***
// Purpose: Host socket controller model driving the card bus
// Assumes: Strobes change at falling edges of clk_sys
// Notes:   Released write data shows the inverse of its last value
`timescale 1ns/10ps
module ccs_host_model (
  // Clock
  input  wire logic        clk_sys,
  // Card bus
  output logic             ce1_n,
  output logic             reg_n,
  output logic             oe_n,
  output logic             we_n,
  output logic             iord_n,
  output logic             iowr_n,
  output logic [10:0]      addr,
  output logic [7:0]       host_d,
  input  wire logic [7:0]  data_bus
);
  initial begin
    {ce1_n, reg_n, oe_n, we_n, iord_n, iowr_n} = 6'h3f;
    addr = 11'h000;
    host_d = 8'h00;
  end
  task automatic idle();
    @(negedge clk_sys);
    {ce1_n, reg_n, oe_n, we_n, iord_n, iowr_n} = 6'h3f;
    host_d = ~host_d;
  endtask
  // One write per falling we_n, high cycle between writes
  task automatic wr(input logic [10:0] a, input logic [7:0] dv);
    @(negedge clk_sys);
    {ce1_n, reg_n, we_n} = 3'h0;
    addr = a;
    host_d = dv;
    @(posedge clk_sys);
    idle();
  endtask
  task automatic rd(input logic [10:0] a, output logic [7:0] dv, output logic oe);
    @(negedge clk_sys);
    {ce1_n, reg_n, oe_n} = 3'h0;
    addr = a;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    dv = data_bus;
    oe = (data_bus === data_bus) && (oe_n === 1'h0);
    idle();
  endtask
  // Memory cycle when io is low, I/O read cycle when high
  task automatic go(input logic io, input logic [10:0] a);
    @(negedge clk_sys);
    {ce1_n, reg_n, oe_n, iord_n} = {1'h0, ~io, io, ~io};
    addr = a;
  endtask
endmodule

// *** test/ccs_config_regs_assertions.sv ***
// Purpose: Port checks for the configuration and status block
// Assumes: SETTLE_CYC matches the bound design
// Notes:   Busy length counted in helper logic
`timescale 1ns/10ps
`include "ccs_consts.svh"
module ccs_config_regs_assertions #(
  parameter int SETTLE_CYC = 4
) (
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               reset_n,
  // Card bus
  input wire logic               ce1_n,
  input wire logic               reg_n,
  input wire logic               oe_n,
  input wire logic               we_n,
  input wire logic               iord_n,
  input wire logic [10:0]        addr,
  input wire logic [7:0]         data_out,
  input wire logic               data_oe,
  // Status and core side
  input wire logic               ready_state,
  input wire logic               ready_change_flag,
  input wire logic               host_irq_disable,
  input wire logic               status_changed_pin_n,
  input wire logic               irq_n,
  input wire logic               card_reset,
  input wire logic               powered_down,
  input wire ccs_pkg::ccs_mode_t mode,
  input wire logic               task_hit,
  input wire logic [3:0]         task_reg
);
  import ccs_pkg::*;
  logic       rd_cfg;
  logic [9:0] low_cnt_r;
  logic [9:0] low_cnt_nxt;
  assign rd_cfg = !ce1_n && !reg_n && !oe_n && we_n &&
                  (addr == `CCS_ATTR_MODE_SEL || addr == `CCS_ATTR_STAT_CTRL);
  always_comb begin
    low_cnt_nxt = ready_state ? 10'h000 : low_cnt_r + 10'h001;
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt_r <= 10'h000;
    end else begin
      low_cnt_r <= low_cnt_nxt;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_busy_min_len: assert property (
    $rose(ready_state) |-> low_cnt_r >= SETTLE_CYC) else $error("busy ended early");
  a_busy_max_len: assert property (
    low_cnt_r <= 2 * SETTLE_CYC + 8) else $error("busy never ends");
  a_ready_chg_set: assert property (
    $changed(ready_state) |-> ##[0:2] ready_change_flag) else $error("ready change lost");
  a_pwr_under_busy: assert property (
    $changed(powered_down) |-> !$past(ready_state) || !$past(ready_state, 2))
    else $error("power state moved while ready");
  a_irq_masked: assert property (
    $past(host_irq_disable) |-> irq_n) else $error("interrupt while disabled");
  a_pin_mem_high: assert property (
    mode == CCS_MODE_MEMORY && $past(mode) == CCS_MODE_MEMORY |-> status_changed_pin_n)
    else $error("status pin low in memory mode");
  a_mem_task_hit: assert property (
    mode == CCS_MODE_MEMORY && !card_reset && !ce1_n && reg_n && !oe_n &&
    (addr[10:4] == 7'h00 || addr[10]) |=> task_hit && task_reg == $past(addr[3:0]))
    else $error("memory task decode wrong");
  a_pri_task_hit: assert property (
    mode == CCS_MODE_PRIMARY && !card_reset && !ce1_n && !reg_n && !iord_n &&
    addr[10:3] == 8'h3e |=> task_hit && task_reg == {1'h0, $past(addr[2:0])})
    else $error("primary task decode wrong");
  a_sec_alt_hit: assert property (
    mode == CCS_MODE_SECONDARY && !card_reset && !ce1_n && !reg_n && !iord_n &&
    addr[10:1] == 10'h1bb |=> task_hit && task_reg == {3'h7, $past(addr[0])})
    else $error("secondary alternate decode wrong");
  a_softrst_nohit: assert property (
    card_reset |=> !task_hit) else $error("decode during soft reset");
  a_oe_cause: assert property (
    $rose(data_oe) |-> $past(rd_cfg)) else $error("data driven without read");
  a_oe_release: assert property (
    data_oe && !rd_cfg |=> !data_oe) else $error("data driven after read");
  a_stat_zero_bits: assert property (
    data_oe && $past(rd_cfg && addr == `CCS_ATTR_STAT_CTRL) |->
    data_out[4:3] == 2'h0 && !data_out[0]) else $error("status zero bits set");
  c_task_hit: cover property (task_hit);
  c_pin_low: cover property (!status_changed_pin_n);
  c_busy: cover property ($fell(ready_state));
endmodule
bind ccs_config_regs ccs_config_regs_assertions #(.SETTLE_CYC(SETTLE_CYC)) chk_inst (
  .clk_sys(clk_sys), .reset_n(reset_n), .ce1_n(ce1_n), .reg_n(reg_n), .oe_n(oe_n),
  .we_n(we_n), .iord_n(iord_n), .addr(addr), .data_out(data_out), .data_oe(data_oe),
  .ready_state(ready_state), .ready_change_flag(ready_change_flag),
  .host_irq_disable(host_irq_disable), .status_changed_pin_n(status_changed_pin_n),
  .irq_n(irq_n), .card_reset(card_reset), .powered_down(powered_down), .mode(mode),
  .task_hit(task_hit), .task_reg(task_reg)
);

// *** test/ccs_config_regs_tb_top.sv ***
// Purpose: Self-checking bench for the configuration and status block
// Assumes: Host model drives the card bus, bench drives the core side
// Notes:   Settle count shortened to 4 cycles
`timescale 1ns/10ps
`include "ccs_consts.svh"
module ccs_config_regs_tb_top;
  import ccs_pkg::*;
  localparam int MS = `CCS_ATTR_MODE_SEL;
  localparam int SC = `CCS_ATTR_STAT_CTRL;
  typedef struct packed {
    logic [5:0]  idx;
    logic        io;
    logic [10:0] a;
    logic        hit;
    logic [3:0]  tr;
    ccs_mode_t   md;
  } ccs_row_t;
  logic        clk_sys, reset_n, ce1_n, reg_n, oe_n, we_n, iord_n, iowr_n, data_oe, oe;
  logic        wp, rclr, rcf, rdy, irq_req, irq_dis, idle, cmd, pin_n, irq_n, crst, pdn, hit;
  logic [10:0] addr;
  logic [7:0]  host_d, data_out, data_bus, d;
  logic [3:0]  treg;
  ccs_mode_t   mode;
  ccs_row_t    rows [10];
  int          err_total, compares, cyc, n;
  assign data_bus = data_oe ? data_out : host_d;
  ccs_config_regs #(.SETTLE_CYC(4)) ccs_config_regs_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .ce1_n(ce1_n), .reg_n(reg_n), .oe_n(oe_n),
    .we_n(we_n), .iord_n(iord_n), .iowr_n(iowr_n), .addr(addr), .data_in(data_bus),
    .data_out(data_out), .data_oe(data_oe), .wp_change_flag(wp), .ready_change_clear(rclr),
    .ready_change_flag(rcf), .ready_state(rdy), .irq_request(irq_req),
    .host_irq_disable(irq_dis), .card_idle(idle), .command_arrive(cmd),
    .status_changed_pin_n(pin_n), .irq_n(irq_n), .card_reset(crst), .powered_down(pdn),
    .mode(mode), .task_hit(hit), .task_reg(treg)
  );
  ccs_host_model host (
    .clk_sys(clk_sys), .ce1_n(ce1_n), .reg_n(reg_n), .oe_n(oe_n), .we_n(we_n),
    .iord_n(iord_n), .iowr_n(iowr_n), .addr(addr), .host_d(host_d), .data_bus(data_bus)
  );
  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      err_total = err_total + 1;
      summarize();
    end
  end
  task automatic summarize();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED %s expected=%h seen=%h", s, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [10:0] a, input logic [7:0] e, input string s);
    host.rd(a, d, oe);
    chk(s, d, e);
  endtask
  task automatic probe(input logic io, input logic [10:0] a);
    host.go(io, a);
    @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse_clear();
    // Let a fresh ready change land first; a change beats a clear
    @(negedge clk_sys);
    rclr = 1'h1;
    @(negedge clk_sys);
    rclr = 1'h0;
  endtask
  task automatic wait_rdy();
    repeat (3) @(negedge clk_sys);
    for (int k = 0; k < 200 && rdy !== 1'h1; k++) @(negedge clk_sys);
    chk("ready", rdy, 1'h1);
  endtask
  initial begin
    {reset_n, wp, rclr, irq_req, irq_dis, idle, cmd} = 7'h00;
    rows = '{'{6'h00, 1'h0, 11'h405, 1'h1, 4'h5, CCS_MODE_MEMORY},
             '{6'h00, 1'h0, 11'h00f, 1'h1, 4'hf, CCS_MODE_MEMORY},
             '{6'h00, 1'h0, 11'h1f0, 1'h0, 4'h0, CCS_MODE_MEMORY},
             '{6'h01, 1'h1, 11'h7a3, 1'h1, 4'h3, CCS_MODE_CONTIG},
             '{6'h02, 1'h1, 11'h1f7, 1'h1, 4'h7, CCS_MODE_PRIMARY},
             '{6'h02, 1'h1, 11'h3f6, 1'h1, 4'he, CCS_MODE_PRIMARY},
             '{6'h02, 1'h1, 11'h170, 1'h0, 4'h0, CCS_MODE_PRIMARY},
             '{6'h03, 1'h1, 11'h172, 1'h1, 4'h2, CCS_MODE_SECONDARY},
             '{6'h03, 1'h1, 11'h377, 1'h1, 4'hf, CCS_MODE_SECONDARY},
             '{6'h05, 1'h1, 11'h1f0, 1'h0, 4'h0, CCS_MODE_CONTIG}};
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'h1;
    foreach (rows[i]) begin
      host.wr(MS, {2'h0, rows[i].idx});
      rd_chk(MS, {2'h0, rows[i].idx}, "mode_sel");
      chk("mode", mode, rows[i].md);
      probe(rows[i].io, rows[i].a);
      chk("task_hit", hit, rows[i].hit);
      if (rows[i].hit) chk("task_reg", treg, rows[i].tr);
      host.idle();
    end
    $display("decode table test done");
    reset_n = 1'h0;
    repeat (3) @(negedge clk_sys);
    reset_n = 1'h1;
    rd_chk(MS, `CCS_MODE_SEL_RESET, "mode_sel_rst");
    rd_chk(SC, `CCS_STAT_CTRL_RESET, "stat_rst");
    chk("mode_rst", mode, CCS_MODE_MEMORY);
    host.wr(SC, 8'hfb);
    rd_chk(SC, 8'h60, "stat_ro");
    $display("reset and field test done");
    host.wr(MS, 8'h01);
    wp = 1'h1;
    repeat (3) @(negedge clk_sys);
    chk("pin_low", pin_n, 1'h0);
    rd_chk(SC, 8'he0, "changed");
    host.wr(SC, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk("pin_off", pin_n, 1'h1);
    host.wr(SC, 8'h40);
    host.wr(MS, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk("pin_mem", pin_n, 1'h1);
    wp = 1'h0;
    irq_req = 1'h1;
    rd_chk(SC, 8'h42, "int_mem");
    irq_dis = 1'h1;
    rd_chk(SC, 8'h40, "int_off");
    {irq_req, irq_dis} = 2'h0;
    for (int lv = 0; lv < 2; lv++) begin
      host.wr(MS, {1'h0, lv[0], 6'h01});
      irq_req = 1'h1;
      n = 0;
      repeat (6) begin
        @(negedge clk_sys);
        n = n + int'(irq_n === 1'h0);
      end
      chk("irq_low_cycles", n[7:0], lv ? 8'h06 : 8'h01);
      irq_req = 1'h0;
    end
    $display("status pin and interrupt test done");
    host.wr(MS, 8'h00);
    host.wr(SC, 8'h04);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("busy_now", rdy, 1'h0);
    wait_rdy();
    chk("pdn_on", pdn, 1'h1);
    chk("rdy_chg", rcf, 1'h1);
    rd_chk(SC, 8'h84, "pwr_rb");
    pulse_clear();
    host.wr(SC, 8'h00);
    wait_rdy();
    chk("pdn_off", pdn, 1'h0);
    idle = 1'h1;
    for (int k = 0; k < 400 && pdn !== 1'h1; k++) @(negedge clk_sys);
    chk("auto_down", pdn, 1'h1);
    idle = 1'h0;
    cmd = 1'h1;
    @(negedge clk_sys);
    cmd = 1'h0;
    wait_rdy();
    chk("auto_up", pdn, 1'h0);
    pulse_clear();
    $display("power test done");
    host.wr(MS, 8'hc3);
    @(negedge clk_sys);
    chk("soft_reset_bit_on", crst, 1'h1);
    rd_chk(MS, 8'h80, "soft_reset_bit_rb");
    probe(1'h1, 11'h172);
    chk("soft_reset_bit_hit", hit, 1'h0);
    host.idle();
    host.wr(SC, 8'h44);
    rd_chk(SC, 8'h00, "soft_reset_bit_stat");
    host.wr(MS, 8'h00);
    @(negedge clk_sys);
    chk("soft_reset_bit_off", crst, 1'h0);
    chk("mode_unconf", mode, CCS_MODE_MEMORY);
    host.rd(11'h20a, d, oe);
    chk("unmapped_oe", data_oe, 1'h0);
    $display("soft reset and unmapped test done");
    summarize();
  end
endmodule
